// ### logic/daq_gain_counter_irq_config.v
`timescale 1ns/1ps
`default_nettype none
`include "daq_defines.vh"

module daq_gain_counter_irq_config (
  input wire clk_in,
  input wire rstn_in,
  input wire board_sel_in,
  input wire [4:0] addr_in,
  input wire ior_n_in,
  input wire iow_n_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_n_out,
  input wire fifo_half_full_in,
  input wire scan_done_in,
  input wire [3:0] channel_in,
  input wire counter_timed_in,
  output reg [1:0] gain_out,
  output reg irq_out,
  output reg freq0_out,
  output reg freq2_out,
  output reg [31:0] cal_pot_out
);

  // Last tick-counter value before the counter clock enable fires.
  // The full-width span is cut to the counter's three bits on purpose.
  localparam [31:0] TICK_SPAN = `CNT_TICK_CYCLES - 1;
  localparam [2:0] TICK_LAST = TICK_SPAN[2:0];

  // Gain codes for stored channels 0-7, two bits each.
  reg [7:0] gain_low;
  reg [7:0] gain_high;
  // Interrupt source enables.
  reg [1:0] irq_enable;
  // Sticky pending flags, one per interrupt source.
  reg [1:0] irq_pending;
  // Previous FIFO half-full level, for edge detection.
  reg half_full_prev;
  // Counter run controls.
  reg [1:0] ctr_control;
  // Counter divisors.
  reg [15:0] ctr0_div;
  reg [31:0] ctr2_div;
  // Previous write strobe, for finding the start of a write.
  reg iow_prev;
  // Counter clock enable generation.
  reg [2:0] tick_count;
  reg tick;
  // Next values of the read path.
  reg [7:0] next_data;
  // Divider and loader outputs before the output flops.
  wire wave0;
  wire wave2;
  wire [7:0] cal_shift;
  wire [31:0] cal_wipers;

  // One write per falling edge of the write strobe while selected.
  wire write_go = board_sel_in && !iow_n_in && iow_prev;
  // Helper: is this write aimed at the given offset.
  function wr_at;
    input [4:0] off;
    begin
      wr_at = write_go && (addr_in == off);
    end
  endfunction

  // Helper: pick the two-bit gain code of a stored channel.
  function [1:0] pick_gain;
    input [7:0] low;
    input [7:0] high;
    input [2:0] ch;
    begin
      if (ch[2])
        pick_gain = high[ch[1:0]*2 +: 2];
      else
        pick_gain = low[ch[1:0]*2 +: 2];
    end
  endfunction

  // Tracks the write strobe so a long strobe yields one write.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      iow_prev <= 1'b1;
    else
      iow_prev <= iow_n_in;
  end

  // Gain code stores, cleared on reset so every channel starts at gain one.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      gain_low <= `GAIN_RESET;
      gain_high <= `GAIN_RESET;
    end
    else
    begin
      // Lower four channels.
      if (wr_at(`OFF_GAIN_LOW))
        gain_low <= data_in;
      // Upper four stored channels.
      if (wr_at(`OFF_GAIN_HIGH))
        gain_high <= data_in;
    end
  end

  // Applies the current channel's code; the top channel bit is ignored,
  // so channels 8-F share the stores of 0-7.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      gain_out <= 2'b00;
    else
      gain_out <= pick_gain(gain_low, gain_high,
        channel_in[2:0]);
  end

  // Interrupt enables, both off after reset.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      irq_enable <= `IRQ_ENABLE_RESET;
    else if (wr_at(`OFF_IRQ_ENABLE))
      irq_enable <= data_in[1:0];
  end

  // Sticky pending flags: a one written to a status bit clears it,
  // but an event in the same cycle wins so that none is lost.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      irq_pending <= 2'b00;
      half_full_prev <= 1'b0;
    end
    else
    begin
      half_full_prev <= fifo_half_full_in;
      // FIFO half-full source: set on the rising edge of the level.
      if (irq_enable[`IRQ_HALF_FULL_BIT] && fifo_half_full_in &&
          !half_full_prev)
        irq_pending[`IRQ_HALF_FULL_BIT] <= 1'b1;
      else if (wr_at(`OFF_IRQ_STATUS) && data_in[`IRQ_HALF_FULL_BIT])
        irq_pending[`IRQ_HALF_FULL_BIT] <= 1'b0;
      // End-of-scan source: set by the scan-complete pulse.
      if (irq_enable[`IRQ_END_SCAN_BIT] && scan_done_in)
        irq_pending[`IRQ_END_SCAN_BIT] <= 1'b1;
      else if (wr_at(`OFF_IRQ_STATUS) && data_in[`IRQ_END_SCAN_BIT])
        irq_pending[`IRQ_END_SCAN_BIT] <= 1'b0;
    end
  end

  // Interrupt request line follows any pending flag.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      irq_out <= 1'b0;
    else
      irq_out <= |irq_pending;
  end

  // Counter control and divisor registers.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctr_control <= `CTR_CONTROL_RESET;
      ctr0_div <= `CTR0_DIV_RESET;
      ctr2_div <= `CTR2_DIV_RESET;
    end
    else
    begin
      // Run bits for the two counters.
      if (wr_at(`OFF_CTR_CONTROL))
        ctr_control <= data_in[1:0];
      // Sixteen-bit divisor, low byte first.
      if (wr_at(`OFF_CTR0_DIV_B0))
        ctr0_div[7:0] <= data_in;
      if (wr_at(`OFF_CTR0_DIV_B1))
        ctr0_div[15:8] <= data_in;
      // Thirty-two-bit divisor, one byte per offset.
      if (wr_at(`OFF_CTR2_DIV_B0))
        ctr2_div[7:0] <= data_in;
      if (wr_at(`OFF_CTR2_DIV_B1))
        ctr2_div[15:8] <= data_in;
      if (wr_at(`OFF_CTR2_DIV_B2))
        ctr2_div[23:16] <= data_in;
      if (wr_at(`OFF_CTR2_DIV_B3))
        ctr2_div[31:24] <= data_in;
    end
  end

  // Makes the 10MHz counter clock as a one-cycle enable.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tick_count <= 3'h0;
      tick <= 1'b0;
    end
    else if (tick_count == TICK_LAST)
    begin
      tick_count <= 3'h0;
      tick <= 1'b1;
    end
    else
    begin
      tick_count <= tick_count + 3'h1;
      tick <= 1'b0;
    end
  end

  // Frequency generator on counter zero.
  freq_divider #(
    .WIDTH(16)
  ) u_ctr0 (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .tick_in(tick),
    .enable_in(ctr_control[`CTR0_RUN_BIT]),
    .divisor_in(ctr0_div),
    .wave_out(wave0)
  );

  // Counter two is only free while the A/D is not counter-timed.
  freq_divider #(
    .WIDTH(32)
  ) u_ctr2 (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .tick_in(tick),
    .enable_in(ctr_control[`CTR2_RUN_BIT] && !counter_timed_in),
    .divisor_in(ctr2_div),
    .wave_out(wave2)
  );

  // Calibration potentiometer settings arrive one bit per write.
  cal_pot_loader u_cal (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .shift_in(wr_at(`OFF_CAL_SHIFT)),
    .bit_in(data_in[`CAL_DATA_BIT]),
    .latch_in(wr_at(`OFF_CAL_LATCH)),
    .index_in(data_in[1:0]),
    .shift_out(cal_shift),
    .wiper_out(cal_wipers)
  );

  // Registers the divider and loader results onto the pins.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      freq0_out <= 1'b0;
      freq2_out <= 1'b0;
      cal_pot_out <= {4{`CAL_POT_CENTER}};
    end
    else
    begin
      freq0_out <= wave0;
      freq2_out <= wave2;
      cal_pot_out <= cal_wipers;
    end
  end

  // Read multiplexer; unused addresses in the block read as zero.
  always @*
  begin
    next_data = `READ_IDLE;
    case (addr_in)
      `OFF_GAIN_LOW: next_data = gain_low;
      `OFF_GAIN_HIGH: next_data = gain_high;
      `OFF_IRQ_ENABLE: next_data = {6'h00, irq_enable};
      `OFF_IRQ_STATUS: next_data = {5'h00, fifo_half_full_in, irq_pending};
      `OFF_CTR0_DIV_B0: next_data = ctr0_div[7:0];
      `OFF_CTR0_DIV_B1: next_data = ctr0_div[15:8];
      `OFF_CTR_CONTROL: next_data = {6'h00, ctr_control};
      `OFF_CTR2_DIV_B0: next_data = ctr2_div[7:0];
      `OFF_CTR2_DIV_B1: next_data = ctr2_div[15:8];
      `OFF_CTR2_DIV_B2: next_data = ctr2_div[23:16];
      `OFF_CTR2_DIV_B3: next_data = ctr2_div[31:24];
      `OFF_CAL_SHIFT: next_data = cal_shift;
      default: next_data = `READ_IDLE;
    endcase
  end

  // Drives the data bus one cycle after a selected read strobe.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      data_out <= `READ_IDLE;
      data_oe_n_out <= 1'b1;
    end
    else
    begin
      data_out <= next_data;
      data_oe_n_out <= !(board_sel_in && !ior_n_in);
    end
  end

endmodule

`default_nettype wire

// ### logic/daq_defines.vh
`ifndef DAQ_DEFINES_VH
`define DAQ_DEFINES_VH

// Register offsets within the 32-address block (address lines A4..A0).
`define OFF_GAIN_LOW 5'h04
`define OFF_GAIN_HIGH 5'h05
`define OFF_IRQ_ENABLE 5'h06
`define OFF_IRQ_STATUS 5'h07
`define OFF_CTR0_DIV_B0 5'h0c
`define OFF_CTR0_DIV_B1 5'h0d
`define OFF_CTR_CONTROL 5'h0e
`define OFF_CTR2_DIV_B0 5'h10
`define OFF_CTR2_DIV_B1 5'h11
`define OFF_CTR2_DIV_B2 5'h12
`define OFF_CTR2_DIV_B3 5'h13
`define OFF_CAL_SHIFT 5'h18
`define OFF_CAL_LATCH 5'h19

// Field positions.
`define IRQ_HALF_FULL_BIT 0
`define IRQ_END_SCAN_BIT 1
`define CTR0_RUN_BIT 0
`define CTR2_RUN_BIT 1
`define CAL_DATA_BIT 0

// Reset values.
`define GAIN_RESET 8'h00
`define IRQ_ENABLE_RESET 2'h0
`define CTR_CONTROL_RESET 2'h0
`define CTR0_DIV_RESET 16'h0000
`define CTR2_DIV_RESET 32'h00000000
`define CAL_POT_CENTER 8'h80
`define READ_IDLE 8'h00

// Timing: the counter clock is derived from the system clock.
`define CLK_HZ 50000000
`define CNT_CLK_HZ 10000000
`define CNT_TICK_CYCLES (`CLK_HZ / `CNT_CLK_HZ)

`endif

// ### logic/freq_divider.v
`timescale 1ns/1ps
`default_nettype none

// Divides the counter tick rate by a programmed divisor n (n >= 2).
module freq_divider #(
  parameter WIDTH = 16
) (
  input wire clk_in,
  input wire rstn_in,
  input wire tick_in,
  input wire enable_in,
  input wire [WIDTH-1:0] divisor_in,
  output reg wave_out
);

  // Down counter over one output period.
  reg [WIDTH-1:0] count;
  // A divisor of zero or one is not a legal setting.
  wire legal = (divisor_in > {{(WIDTH-1){1'b0}}, 1'b1});

  // The output is high for the upper half of each period of n ticks.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count <= {WIDTH{1'b0}};
      wave_out <= 1'b0;
    end
    else if (!enable_in || !legal)
    begin
      // Stopped or illegal divisor: hold the output low.
      count <= {WIDTH{1'b0}};
      wave_out <= 1'b0;
    end
    else if (tick_in)
    begin
      // Reload at the end of a period, otherwise count down.
      if (count == {WIDTH{1'b0}})
        count <= divisor_in - {{(WIDTH-1){1'b0}}, 1'b1};
      else
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      wave_out <= (count >= (divisor_in >> 1));
    end
  end

endmodule

`default_nettype wire

// ### logic/cal_pot_loader.v
`timescale 1ns/1ps
`default_nettype none
`include "daq_defines.vh"

// Bit-serial loader for four calibration potentiometer settings.
module cal_pot_loader (
  input wire clk_in,
  input wire rstn_in,
  input wire shift_in,
  input wire bit_in,
  input wire latch_in,
  input wire [1:0] index_in,
  output reg [7:0] shift_out,
  output reg [31:0] wiper_out
);

  // Shift in one bit per host write, most significant bit first.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      shift_out <= 8'h00;
    else if (shift_in)
      shift_out <= {shift_out[6:0], bit_in};
  end

  // Wipers power up at mid range until a setting is latched.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      wiper_out <= {4{`CAL_POT_CENTER}};
    else if (latch_in)
      wiper_out[index_in*8 +: 8] <= shift_out;
  end

endmodule

`default_nettype wire

// ### testbench/daq_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register port, interrupt and wave outputs.
module daq_cfg_checker (
  input wire clk_in,
  input wire rstn_in,
  input wire board_sel_in,
  input wire [4:0] addr_in,
  input wire ior_n_in,
  input wire iow_n_in,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire data_oe_n_out,
  input wire fifo_half_full_in,
  input wire scan_done_in,
  input wire [3:0] channel_in,
  input wire counter_timed_in,
  input wire [1:0] gain_out,
  input wire irq_out,
  input wire freq0_out,
  input wire freq2_out,
  input wire [31:0] cal_pot_out
);
  logic iow_q; // Write strobe at the last edge.
  logic half_q; // Half-full level at the last edge.
  logic [1:0] en; // Mirror of the interrupt enables.
  logic [2:0] hist; // Writes taken in the last three edges.
  wire wr = board_sel_in & ~iow_n_in & iow_q;
  wire latch_wr = wr & (addr_in == 5'h19);
  wire [2:0] ch_lo = channel_in[2:0];
  wire ev = (scan_done_in & en[1]) | (fifo_half_full_in & ~half_q & en[0]);
  // Tracks taken writes and the enables that they set.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      iow_q <= 1'b1;
      half_q <= 1'b0;
      en <= 2'h0;
      hist <= 3'h0;
    end
    else
    begin
      iow_q <= iow_n_in;
      half_q <= fifo_half_full_in;
      hist <= {hist[1:0], wr};
      if (wr && addr_in == 5'h06)
      begin
        en <= data_in[1:0];
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_READ_OE: assert property (board_sel_in && !ior_n_in |=>
    !data_oe_n_out) else $error("read data not driven");
  AST_IDLE_OE: assert property (!(board_sel_in && !ior_n_in) |=>
    data_oe_n_out) else $error("data driven without read");
  AST_UNMAPPED: assert property (board_sel_in && !ior_n_in &&
    addr_in == 5'h1f |=> data_out == 8'h00) else $error("unmapped read");
  AST_HALF_IRQ: assert property (fifo_half_full_in && !half_q &&
    en[0] |-> ##2 irq_out) else $error("half-full irq missing");
  AST_SCAN_IRQ: assert property (scan_done_in && en[1] |->
    ##2 irq_out) else $error("end-of-scan irq missing");
  AST_IRQ_CAUSE: assert property ($rose(irq_out) |-> $past(ev, 2))
    else $error("irq without enabled event");
  AST_FREQ0_HIGH: assert property ($rose(freq0_out) |->
    freq0_out[*5]) else $error("counter zero pulse short");
  AST_FREQ2_BLOCK: assert property (counter_timed_in[*3] |->
    !freq2_out) else $error("counter two runs while timed");
  AST_CAL_HOLD: assert property ($changed(cal_pot_out) |->
    $past(latch_wr, 2)) else $error("pot moved without latch");
  AST_GAIN_HOLD: assert property (hist == 3'h0 &&
    $past(ch_lo) == $past(ch_lo, 2) |-> $stable(gain_out))
    else $error("gain moved without cause");
  cover property ($rose(irq_out));
  cover property ($rose(freq2_out));
  cover property (latch_wr);
endmodule
bind daq_gain_counter_irq_config daq_cfg_checker chk (.clk_in(clk_in),
  .rstn_in(rstn_in), .board_sel_in(board_sel_in), .addr_in(addr_in),
  .ior_n_in(ior_n_in), .iow_n_in(iow_n_in), .data_in(data_in),
  .data_out(data_out), .data_oe_n_out(data_oe_n_out),
  .fifo_half_full_in(fifo_half_full_in), .scan_done_in(scan_done_in),
  .channel_in(channel_in), .counter_timed_in(counter_timed_in),
  .gain_out(gain_out), .irq_out(irq_out), .freq0_out(freq0_out),
  .freq2_out(freq2_out), .cal_pot_out(cal_pot_out));
`default_nettype wire

// ### testbench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the I/O bus; idle data lines show the inverse of the last byte.
module host_bus_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_oe_n_in,
  output logic sel_out,
  output logic [4:0] addr_out,
  output logic ior_n_out,
  output logic iow_n_out,
  output logic [7:0] wr_data_out
);
  initial
  begin
    sel_out = 1'b0;
    addr_out = 5'h00;
    ior_n_out = 1'b1;
    iow_n_out = 1'b1;
    wr_data_out = 8'h00;
  end
  // One write; the strobe rises again before the next one starts.
  task wr(input logic [4:0] a, input logic [7:0] d);
  begin
    @(posedge clk_in);
    #1;
    sel_out = 1'b1;
    addr_out = a;
    wr_data_out = d;
    iow_n_out = 1'b0;
    @(posedge clk_in);
    #1;
    sel_out = 1'b0;
    iow_n_out = 1'b1;
    wr_data_out = ~d;
  end
  endtask
  // One read; data counts only while the board drives the bus.
  task rd(input logic [4:0] a, output logic [7:0] d);
  begin
    @(posedge clk_in);
    #1;
    sel_out = 1'b1;
    addr_out = a;
    ior_n_out = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    d = (rd_oe_n_in === 1'b0) ? rd_data_in : 8'hxx;
    sel_out = 1'b0;
    ior_n_out = 1'b1;
  end
  endtask
  // Shifts a pot setting in bit by bit, MSB first, then latches it.
  task cal(input logic [1:0] idx, input logic [7:0] v);
  begin
    for (int i = 7; i >= 0; i--) wr(5'h18, {7'h00, v[i]});
    wr(5'h19, {6'h00, idx});
  end
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_daq_gain_counter_irq_config.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_daq_gain_counter_irq_config;
  logic clk_in = 1'b0; // System clock.
  logic rstn_in = 1'b0; // Reset, low at start.
  logic half = 1'b0; // FIFO half-full level.
  logic scan = 1'b0; // End-of-scan pulse.
  logic timed = 1'b0; // Counter-timed A/D mode.
  logic [3:0] chan = 4'h0; // Current channel.
  wire sel, ior_n, iow_n, oe_n, irq, f0, f2;
  wire [4:0] addr;
  wire [7:0] din, dout;
  wire [1:0] gain;
  wire [31:0] cal;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] r;
  logic [7:0] e;
  always #10 clk_in = ~clk_in;
  host_bus_model host (.clk_in(clk_in), .rd_data_in(dout),
    .rd_oe_n_in(oe_n), .sel_out(sel), .addr_out(addr), .ior_n_out(ior_n),
    .iow_n_out(iow_n), .wr_data_out(din));
  daq_gain_counter_irq_config uut (.clk_in(clk_in), .rstn_in(rstn_in),
    .board_sel_in(sel), .addr_in(addr), .ior_n_in(ior_n),
    .iow_n_in(iow_n), .data_in(din), .data_out(dout),
    .data_oe_n_out(oe_n), .fifo_half_full_in(half), .scan_done_in(scan),
    .channel_in(chan), .counter_timed_in(timed), .gain_out(gain),
    .irq_out(irq), .freq0_out(f0), .freq2_out(f2), .cal_pot_out(cal));
  // Prints the counts and the verdict, then stops.
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task tk(input int c);
  begin
    repeat (c) @(posedge clk_in);
    #1;
  end
  endtask
  // Waits, at most 100 cycles, for the chosen wave to reach a level.
  task wt(input bit w, input bit v);
    int k;
  begin
    k = 0;
    while (((w ? f2 : f0) !== v) && k < 100)
    begin
      tk(1);
      k++;
      n++;
    end
  end
  endtask
  // Measures one full period of the chosen wave in clock cycles.
  task per(input bit w, input int p);
  begin
    wt(w, 1'b0);
    wt(w, 1'b1);
    n = 0;
    wt(w, 1'b0);
    wt(w, 1'b1);
    `CHK("period", p, n)
  end
  endtask
  // Cuts a hang short.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      finish_test;
    end
  end
  initial
  begin
    tk(2);
    rstn_in = 1'b1;
    `CHK("gain", 2'h0, gain)
    `CHK("irq", 1'b0, irq)
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("pots", 32'h80808080, cal)
    $display("reset test done");
    host.wr(5'h04, 8'he4);
    host.wr(5'h05, 8'h1b);
    host.wr(5'h1f, 8'hff);
    host.rd(5'h04, r);
    `CHK("gain low", 8'he4, r)
    host.rd(5'h05, r);
    `CHK("gain high", 8'h1b, r)
    host.rd(5'h1f, r);
    `CHK("unmapped", 8'h00, r)
    for (int k = 0; k < 16; k++)
    begin
      chan = k[3:0];
      tk(2);
      e = (k[2] ? 8'h1b : 8'he4) >> (2 * k[1:0]);
      `CHK("channel gain", e[1:0], gain)
    end
    $display("gain test done");
    half = 1'b1;
    scan = 1'b1;
    tk(1);
    scan = 1'b0;
    tk(4);
    `CHK("irq disabled", 1'b0, irq)
    half = 1'b0;
    host.wr(5'h06, 8'h02);
    scan = 1'b1;
    tk(1);
    scan = 1'b0;
    tk(2);
    `CHK("scan irq", 1'b1, irq)
    host.wr(5'h07, 8'h02);
    tk(2);
    `CHK("irq cleared", 1'b0, irq)
    host.wr(5'h06, 8'h01);
    half = 1'b1;
    tk(3);
    `CHK("half irq", 1'b1, irq)
    host.rd(5'h07, r);
    `CHK("status", 8'h05, r)
    host.wr(5'h07, 8'h01);
    tk(2);
    `CHK("half cleared", 1'b0, irq)
    half = 1'b0;
    $display("irq test done");
    host.wr(5'h0c, 8'h02);
    host.wr(5'h10, 8'h03);
    host.wr(5'h0e, 8'h03);
    per(1'b0, 10);
    per(1'b1, 15);
    timed = 1'b1;
    tk(3);
    for (int k = 0; k < 20; k++)
    begin
      tk(1);
      `CHK("ctr2 blocked", 1'b0, f2)
    end
    host.wr(5'h0d, 8'h01);
    host.rd(5'h0d, r);
    `CHK("ctr0 high byte", 8'h01, r)
    host.wr(5'h13, 8'h80);
    host.rd(5'h13, r);
    `CHK("ctr2 top byte", 8'h80, r)
    $display("counter test done");
    host.cal(2'h1, 8'ha5);
    tk(2);
    `CHK("pots", 32'h8080a580, cal)
    $display("calibration test done");
    rstn_in = 1'b0;
    tk(2);
    rstn_in = 1'b1;
    `CHK("pots after reset", 32'h80808080, cal)
    `CHK("irq after reset", 1'b0, irq)
    host.rd(5'h04, r);
    `CHK("gain low after reset", 8'h00, r)
    host.rd(5'h06, r);
    `CHK("irq enable after reset", 8'h00, r)
    $display("second reset test done");
    finish_test;
  end
endmodule
`default_nettype wire
